// ### rtl/scl_irq_pkg.sv
/*
  shared constants of the serial clock and interrupt block: register offsets,
  field positions, reset values and bus response codes.
  assumes a 32-bit axi4-lite register bus and a 50 mhz system clock.
*/
package scl_irq_pkg;
  // system clock period, and the prescaler window that software must respect
  localparam int CLK_PERIOD_NS = 20;
  localparam int PRS_MIN_NS = 50;
  localparam int PRS_MAX_NS = 150;
  // byte addresses of the register words
  localparam logic [31:0] CONTROL_ONE_OFS = 32'h0000_0000;
  localparam logic [31:0] CONTROL_TWO_OFS = 32'h0000_0004;
  localparam logic [31:0] PRESCALE_REG_OFS = 32'h0000_0008;
  localparam logic [31:0] IRQ_ENABLE_OFS = 32'h0000_000C;
  localparam logic [31:0] IRQ_STATUS_CLEAR_OFS = 32'h0000_0010;
  localparam logic [31:0] BUS_STATE_OFS = 32'h0000_0014;
  // field positions
  localparam int SCK_LSB = 0;
  localparam int MST_BIT = 0;
  localparam int START_BIT = 1;
  localparam int STOP_BIT = 2;
  localparam int RELEASE_BIT = 3;
  localparam int PRS_LSB = 0;
  localparam int GATE_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int SCL_SEEN_BIT = 1;
  localparam int SDA_SEEN_BIT = 2;
  // reset values
  localparam logic [2:0] SCK_RST = 3'h0;
  localparam logic [4:0] PRS_RST = 5'h01;
  // high time is 2^(n+1)+6 periods, low time four more
  localparam logic [8:0] HIGH_BASE = 9'h006;
  localparam logic [8:0] LOW_EXTRA = 9'h004;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_START = 6'b00_0010,
    ST_LOW = 6'b00_0100,
    ST_HIGH = 6'b00_1000,
    ST_STOP = 6'b01_0000,
    ST_STRETCH = 6'b10_0000
  } scl_state_t;
endpackage

// ### rtl/scl_irq_ctrl.sv
/*
  serial clock generator, input noise filter and interrupt flag logic of a
  two-wire bus controller, with an axi4-lite register slave.
  assumes bus pins are open drain with external pull-ups, that inputs are
  synchronous to clk, and that the data path pulses xfer_event per event.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module scl_irq_ctrl
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic xfer_event,
  output logic controller_irq_out
);
  import scl_irq_pkg::*;

  // high time in prescaler periods for period selector n
  function automatic logic [8:0] high_len(input logic [2:0] n);
    high_len = (9'h001 << (4'(n) + 4'h1)) + HIGH_BASE;
  endfunction

  // one line of the noise filter: accept a new level only after p stable cycles
  function automatic logic [5:0] filt_step(input logic raw, input logic filt, input logic [4:0] cnt,
                                           input logic [4:0] last);
    if (raw == filt) filt_step = {filt, 5'h00};
    else if (cnt == last) filt_step = {raw, 5'h00};
    else filt_step = {filt, cnt + 5'h01};
  endfunction

  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a == CONTROL_ONE_OFS) || (a == CONTROL_TWO_OFS) || (a == PRESCALE_REG_OFS) ||
              (a == IRQ_ENABLE_OFS) || (a == IRQ_STATUS_CLEAR_OFS) || (a == BUS_STATE_OFS);
  endfunction

  // bus slave state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] aw_addr_q, aw_addr_d, w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  // software visible state
  logic [2:0] sck_q, sck_d;
  logic mst_q, mst_d;
  logic [4:0] prs_q, prs_d;
  logic gate_q, gate_d;
  logic raw_q, raw_d;
  logic start_pend_q, start_pend_d, stop_pend_q, stop_pend_d, rel_pend_q, rel_pend_d;
  logic irq_d;
  // clock engine
  scl_state_t state_q, state_d;
  logic [8:0] cnt_q, cnt_d;
  logic [4:0] pcnt_q, pcnt_d, scl_fc_q, scl_fc_d, sda_fc_q, sda_fc_d;
  logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;
  logic scl_oe_d, sda_oe_d;
  logic seen_high_q, seen_high_d;

  logic [4:0] p_last;
  logic tick;
  logic [8:0] t_high, t_low;
  logic wr_fire, wr_ok;
  logic ev_start, ev_stop;

  // prescaler: code 0 wraps to 31, giving divide by 32 with no special case
  assign p_last = prs_q - 5'h01;
  assign tick = (pcnt_q == p_last);
  assign t_high = high_len(sck_q);
  assign t_low = t_high + LOW_EXTRA;
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign wr_ok = wr_fire && reg_hit(aw_addr_q) && w_lane_q;

  // bus channels: address and data are held separately so either may come first
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid;
    bresp_d = bresp;
    rvalid_d = rvalid;
    rdata_d = rdata;
    rresp_d = rresp;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_lane_d = wstrb[0]; // every field lives in byte lane 0
    end
    if (bvalid && bready) bvalid_d = 1'b0;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready) rvalid_d = 1'b0;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (araddr == CONTROL_ONE_OFS) rdata_d[SCK_LSB +: 3] = sck_q;
      else if (araddr == CONTROL_TWO_OFS) rdata_d[MST_BIT] = mst_q;
      else if (araddr == PRESCALE_REG_OFS) rdata_d[PRS_LSB +: 5] = prs_q;
      else if (araddr == IRQ_ENABLE_OFS) rdata_d[GATE_BIT] = gate_q;
      else if (araddr == IRQ_STATUS_CLEAR_OFS) rdata_d[FLAG_BIT] = raw_q;
      else if (araddr == BUS_STATE_OFS) begin
        rdata_d[BUSY_BIT] = (state_q != ST_IDLE);
        rdata_d[SCL_SEEN_BIT] = scl_f_q;
        rdata_d[SDA_SEEN_BIT] = sda_f_q;
      end else rresp_d = RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // register writes and the interrupt flag; an event beats a clear in the same cycle
  always_comb begin
    sck_d = sck_q;
    mst_d = mst_q;
    prs_d = prs_q;
    gate_d = gate_q;
    raw_d = raw_q;
    start_pend_d = start_pend_q && !ev_start;
    stop_pend_d = stop_pend_q && !ev_stop;
    rel_pend_d = rel_pend_q && (state_q == ST_STRETCH);
    if (wr_ok) begin
      if (aw_addr_q == CONTROL_ONE_OFS) sck_d = w_data_q[SCK_LSB +: 3];
      else if (aw_addr_q == CONTROL_TWO_OFS) begin
        mst_d = w_data_q[MST_BIT];
        if (w_data_q[START_BIT]) start_pend_d = 1'b1;
        if (w_data_q[STOP_BIT]) stop_pend_d = 1'b1;
        if (w_data_q[RELEASE_BIT]) rel_pend_d = 1'b1;
      end else if (aw_addr_q == PRESCALE_REG_OFS) prs_d = w_data_q[PRS_LSB +: 5];
      else if (aw_addr_q == IRQ_ENABLE_OFS) gate_d = w_data_q[GATE_BIT];
      else if (aw_addr_q == IRQ_STATUS_CLEAR_OFS && w_data_q[FLAG_BIT]) raw_d = 1'b0;
    end
    if (ev_start || ev_stop || xfer_event) raw_d = 1'b1;
    irq_d = raw_d && gate_d;
  end

  // prescaler counter and the two line filters; the counter rests at zero while idle or while a
  // stretch waits for release, so start hold and release delay are whole prescaler periods
  always_comb begin
    if (tick || state_q == ST_IDLE || (state_q == ST_STRETCH && !rel_pend_q)) pcnt_d = 5'h00;
    else pcnt_d = pcnt_q + 5'h01;
    {scl_f_d, scl_fc_d} = filt_step(scl_in, scl_f_q, scl_fc_q, p_last);
    {sda_f_d, sda_fc_d} = filt_step(sda_in, sda_f_q, sda_fc_q, p_last);
  end

  // scl state machine; all phase lengths are counted in prescaler ticks
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    seen_high_d = seen_high_q;
    ev_start = 1'b0;
    ev_stop = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 9'h000;
        if (mst_q && start_pend_q && scl_f_q && sda_f_q) state_d = ST_START;
        else if (!mst_q && xfer_event) state_d = ST_STRETCH;
      end
      ST_START: begin
        if (tick) cnt_d = cnt_q + 9'h001;
        if (tick && cnt_q == t_high - 9'h001) begin
          state_d = ST_LOW;
          cnt_d = 9'h000;
          ev_start = 1'b1;
        end
      end
      ST_LOW: begin
        if (tick) cnt_d = cnt_q + 9'h001;
        if (tick && cnt_q == t_low - 9'h001) begin
          state_d = stop_pend_q ? ST_STOP : ST_HIGH;
          cnt_d = 9'h000;
          seen_high_d = 1'b0;
        end
      end
      ST_HIGH: begin
        if (scl_f_q) seen_high_d = 1'b1;
        if (seen_high_q && !scl_f_q) begin
          state_d = ST_LOW;
          cnt_d = 9'h000;
        end else if (tick && scl_f_q) begin
          cnt_d = cnt_q + 9'h001;
          if (cnt_q == t_high - 9'h001) begin
            state_d = ST_LOW;
            cnt_d = 9'h000;
          end
        end
      end
      ST_STOP: begin
        if (tick && scl_f_q) begin
          cnt_d = cnt_q + 9'h001;
          if (cnt_q == t_high - 9'h001) begin
            state_d = ST_IDLE;
            cnt_d = 9'h000;
            ev_stop = 1'b1;
          end
        end
      end
      ST_STRETCH: begin
        if (rel_pend_q && tick) begin
          cnt_d = cnt_q + 9'h001;
          if (cnt_q == t_low - 9'h001) begin
            state_d = ST_IDLE;
            cnt_d = 9'h000;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 9'h000;
      end
    endcase
    // pins are driven low only; a released pin floats high on the pull-up
    scl_oe_d = (state_d == ST_LOW) || (state_d == ST_STRETCH);
    sda_oe_d = (state_d == ST_START) || (state_d == ST_STOP) ||
               (state_d == ST_LOW && state_q == ST_START);
  end

  // register stage for everything above
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      sck_q <= SCK_RST;
      mst_q <= 1'b0;
      prs_q <= PRS_RST;
      gate_q <= 1'b0;
      raw_q <= 1'b0;
      start_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      rel_pend_q <= 1'b0;
      controller_irq_out <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= 9'h000;
      seen_high_q <= 1'b0;
      pcnt_q <= 5'h00;
      scl_fc_q <= 5'h00;
      sda_fc_q <= 5'h00;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
      sck_q <= sck_d;
      mst_q <= mst_d;
      prs_q <= prs_d;
      gate_q <= gate_d;
      raw_q <= raw_d;
      start_pend_q <= start_pend_d;
      stop_pend_q <= stop_pend_d;
      rel_pend_q <= rel_pend_d;
      controller_irq_out <= irq_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      seen_high_q <= seen_high_d;
      pcnt_q <= pcnt_d;
      scl_fc_q <= scl_fc_d;
      sda_fc_q <= sda_fc_d;
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
      scl_oe <= scl_oe_d;
      sda_oe <= sda_oe_d;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_irq_gating: assert property (controller_irq_out == (raw_q && gate_q))
    else $error("interrupt output disagrees with flag and gate");
  // a new event may set the flag again one cycle after the clear, so only the next cycle is checked
  chk_clear_one: assert property (wr_ok && aw_addr_q == IRQ_STATUS_CLEAR_OFS && w_data_q[FLAG_BIT] &&
    !ev_start && !ev_stop && !xfer_event |=> !raw_q && !controller_irq_out)
    else $error("write of one did not clear the flag");
  chk_clear_zero: assert property (raw_q && !(wr_ok && aw_addr_q == IRQ_STATUS_CLEAR_OFS &&
    w_data_q[FLAG_BIT]) |=> raw_q)
    else $error("flag dropped without a clearing write");
  chk_gate_read: assert property (arvalid && arready && araddr == IRQ_ENABLE_OFS
    |=> rvalid && rdata == {31'h0000_0000, $past(gate_q)})
    else $error("enable register read back wrong");
  chk_flag_read: assert property (arvalid && arready && araddr == IRQ_STATUS_CLEAR_OFS
    |=> rdata == {31'h0000_0000, $past(raw_q)})
    else $error("status read does not show raw flag");
  chk_low_len: assert property (state_q == ST_LOW && state_d != ST_LOW
    |-> tick && cnt_q == t_low - 9'h001 && t_low == t_high + 9'h004)
    else $error("scl low phase has wrong length");
  chk_high_len: assert property (state_q == ST_HIGH && state_d == ST_LOW && scl_f_q
    |-> tick && cnt_q == t_high - 9'h001)
    else $error("scl high phase has wrong length");
  chk_start_hold: assert property (state_q == ST_START && state_d != ST_START
    |-> cnt_q == t_high - 9'h001 ##1 scl_oe && sda_oe)
    else $error("start hold time wrong");
  chk_slave_release: assert property (state_q == ST_STRETCH && state_d == ST_IDLE
    |-> rel_pend_q && cnt_q == t_low - 9'h001 ##1 !scl_oe)
    else $error("slave release delay wrong");
  chk_presc_div: assert property (tick |-> pcnt_q == prs_q - 5'h01 ##1 pcnt_q == 5'h00)
    else $error("prescaler tick out of place");
  chk_reset_div: assert property ($past(!rst_n) |-> prs_q == PRS_RST)
    else $error("prescaler not divide by one after reset");
  chk_filter_len: assert property (scl_f_q != $past(scl_f_q) |-> $past(scl_fc_q) == $past(p_last))
    else $error("scl filter accepted a short pulse");
  chk_sync_pause: assert property (state_q == ST_HIGH && !scl_f_q |=> cnt_q == $past(cnt_q)
    || state_q == ST_LOW)
    else $error("high count advanced while line low");
endmodule // scl_irq_ctrl

`default_nettype wire

// ### bench/bus_partner.sv
/*
  far side of the two-wire bus: pull-ups on both lines and one other party
  that can hold the serial clock low for a commanded number of cycles.
  assumes the bench chooses every stretch length and keeps its timing rules.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic stretch_go,
  input wire logic [15:0] stretch_len,
  output logic scl_line,
  output logic sda_line
);
  logic [15:0] hold_q;
  logic [15:0] hold_d;

  // stretch length is at least five prescaler periods, the bench sees to it
  always_comb begin
    hold_d = hold_q;
    if (stretch_go) hold_d = stretch_len;
    else if (hold_q != 16'h0000) hold_d = hold_q - 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) hold_q <= 16'h0000;
    else hold_q <= hold_d;
  end

  // wired-and with pull-ups: a released line goes high, never keeps a stale value
  assign scl_line = ~scl_oe & (hold_q == 16'h0000);
  assign sda_line = ~sda_oe;
endmodule // bus_partner

`default_nettype wire

// ### bench/testbench.sv
/*
  self-checking bench of the serial clock and interrupt block: register
  table, master clock timing, stretching, slave release and interrupt flag.
  assumes the design package and the far-side model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import scl_irq_pkg::*;
  typedef struct {logic we; logic [31:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  typedef struct {int n; int p;} ck_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, scl_line, sda_line;
  logic [1:0] bresp, rresp, r;
  logic xfer_event = 1'b0, stretch_go = 1'b0;
  logic [15:0] stretch_len = 16'h0000;
  int error_cnt = 0, tests_run = 0, n, p, th, tl;
  row_t rows [13];
  ck_t cks [3];

  always #10 clk = ~clk;

  scl_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(), .sda_oe(sda_oe), .xfer_event(xfer_event), .controller_irq_out(irq));

  bus_partner far_end (.clk(clk), .rst_n(rst_n), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch_go(stretch_go),
    .stretch_len(stretch_len), .scl_line(scl_line), .sda_line(sda_line));

  // address and data offered together, each released once taken; the idle edge first keeps
  // bready from being lowered and raised again in one step; only the watchdog ends a wait
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a width in clocks: phase start may slip within one prescaler period plus filter lag
  task automatic chk_w(input string nm, input int base, input int pp, input int g);
    tests_run++;
    if (g < base * pp - 2 || g > base * pp + 2 * pp + 3) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", nm, base * pp, g);
    end
  endtask

  // counts clocks until the chosen line (0 clock, 1 data) shows the level
  task automatic wait_ln(input logic s, input logic lv, output int cnt);
    cnt = 0;
    while ((s ? sda_line : scl_line) !== lv && cnt < 20000) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rows = '{
      '{1'b0, CONTROL_TWO_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b0, BUS_STATE_OFS, 32'h0000_0000, 32'h0000_0006, RESP_OKAY},
      '{1'b0, CONTROL_ONE_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b0, PRESCALE_REG_OFS, 32'h0000_0000, 32'h0000_0001, RESP_OKAY},
      '{1'b0, IRQ_ENABLE_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b0, IRQ_STATUS_CLEAR_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b1, PRESCALE_REG_OFS, 32'hFFFF_FFFF, 32'h0000_001F, RESP_OKAY},
      '{1'b1, PRESCALE_REG_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b1, CONTROL_ONE_OFS, 32'hFFFF_FFFF, 32'h0000_0007, RESP_OKAY},
      '{1'b1, IRQ_ENABLE_OFS, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY},
      '{1'b1, IRQ_ENABLE_OFS, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{1'b1, IRQ_STATUS_CLEAR_OFS, 32'hFFFF_FFFF, 32'h0000_0000, RESP_OKAY},
      '{1'b1, 32'h0000_0020, 32'h0000_BEEF, 32'h0000_0000, RESP_SLVERR}};
    // prescaler periods of 60, 140 and 100 ns stay inside the allowed window
    cks = '{'{0, 3}, '{1, 7}, '{2, 5}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // register table: reset values, access kinds, unmapped place
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].a, rows[i].d, r);
        chk("write response", {30'h0, rows[i].r}, {30'h0, r});
      end
      rd(rows[i].a, v, r);
      chk("read data", rows[i].e, v);
      chk("read response", {30'h0, rows[i].r}, {30'h0, r});
    end
    $display("test registers done");
    // master clock: start hold, low, high, stretched low, stop setup
    foreach (cks[i]) begin
      p = cks[i].p;
      th = (1 << (cks[i].n + 1)) + 6;
      tl = th + 4;
      wr(PRESCALE_REG_OFS, 32'(p), r);
      wr(CONTROL_ONE_OFS, 32'(cks[i].n), r);
      wr(CONTROL_TWO_OFS, 32'h0000_0003, r);
      wait_ln(1'b1, 1'b0, n);
      wait_ln(1'b0, 1'b0, n);
      chk_w("start hold", th, p, n);
      wait_ln(1'b0, 1'b1, n);
      chk_w("scl low", tl, p, n);
      wait_ln(1'b0, 1'b0, n);
      chk_w("scl high", th, p, n);
      stretch_go <= 1'b1;
      stretch_len <= 16'(tl * p + 40);
      @(posedge clk);
      stretch_go <= 1'b0;
      wait_ln(1'b0, 1'b1, n);
      chk_w("stretched low", tl * p + 40, 1, n);
      wait_ln(1'b0, 1'b0, n);
      chk_w("high after stretch", th, p, n);
      wr(CONTROL_TWO_OFS, 32'h0000_0005, r);
      wait_ln(1'b1, 1'b0, n);
      wait_ln(1'b0, 1'b1, n);
      wait_ln(1'b1, 1'b1, n);
      chk_w("stop setup", th, p, n);
      rd(IRQ_STATUS_CLEAR_OFS, v, r);
      chk("flag after stop", 32'h0000_0001, v);
      wr(IRQ_STATUS_CLEAR_OFS, 32'h0000_0001, r);
    end
    $display("test master clock done");
    // slave stretch, gating and clearing of the interrupt
    wr(CONTROL_TWO_OFS, 32'h0000_0000, r);
    wr(IRQ_ENABLE_OFS, 32'h0000_0001, r);
    xfer_event <= 1'b1;
    @(posedge clk);
    xfer_event <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    chk("scl held", 32'h0000_0000, {31'h0, scl_line});
    wr(IRQ_ENABLE_OFS, 32'h0000_0000, r);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    rd(IRQ_STATUS_CLEAR_OFS, v, r);
    chk("raw flag masked", 32'h0000_0001, v);
    wr(IRQ_STATUS_CLEAR_OFS, 32'h0000_0000, r);
    rd(IRQ_STATUS_CLEAR_OFS, v, r);
    chk("flag after zero write", 32'h0000_0001, v);
    wr(IRQ_ENABLE_OFS, 32'h0000_0001, r);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    wr(CONTROL_TWO_OFS, 32'h0000_0008, r);
    wait_ln(1'b0, 1'b1, n);
    chk_w("slave release", tl, p, n);
    wr(IRQ_STATUS_CLEAR_OFS, 32'h0000_0001, r);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rd(IRQ_STATUS_CLEAR_OFS, v, r);
    chk("flag cleared", 32'h0000_0000, v);
    $display("test interrupt done");
    complete_run();
  end
endmodule // testbench

`default_nettype wire
